// *** core/sac_ctrl.sv ***
/*
 Controller of a 10-bit successive-approximation converter: mode
 register, approximation register, result registers, pin routing.
 Assumes a single-cycle CPU bus with a wait output, and a comparator
 that returns a digital decision in step with the clock.
*/
`timescale 1ns/1ns
module sac_ctrl
	import sac_pkg::*;
#(
	parameter int NPINS = 6
) (
	input wire logic CLK_SYS, // Peripheral clock
	input wire logic RSTN, // Async reset, low
	input wire logic [15:0] BUS_ADDR, // CPU address
	input wire logic BUS_WR, // Write strobe
	input wire logic BUS_RD, // Read strobe
	input wire logic [7:0] BUS_WDATA, // Write data
	output logic [7:0] BUS_RDATA, // Read data
	output logic BUS_WAIT, // Wait cycle
	input wire logic CMP_OUT, // Comparator decision
	output logic CMP_POWER, // Comparator powered
	output logic [9:0] DAC_CODE, // Resistor tap code
	output logic SH_TRACK, // Sample-hold tracking
	output logic [2:0] SH_CHANNEL, // Selected input
	output logic [NPINS-1:0] PIN_ANALOG, // Pin routed as analog
	output logic [NPINS-1:0] PIN_SEGMENT, // Pin as segment output
	output logic [NPINS-1:0] PIN_OE, // Port output enable
	output logic RESULT_INVALID, // Latest result unsettled
	output logic DONE_IRQ // Completion pulse
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] mode_r;
	logic [2:0] chan_r;
	logic [5:0] pincfg_r;
	logic [5:0] pfunc_r;
	logic [5:0] pdir_r;
	logic [9:0] sar_r;
	logic [9:0] result_r;
	logic [7:0] res_byte_r;
	logic [3:0] bit_r;
	logic [5:0] div_r;
	logic [1:0] samp_r;
	logic [7:0] settle_r;
	logic first_r;
	logic first_bad_r;
	logic wait_r;
	logic [7:0] rdata_r;
	logic done_r;
	logic inval_r;
	sac_state_t state_r;
	logic run;
	logic cmp_en;
	logic step;
	logic [5:0] div_max;
	logic [3:0] fr;
	logic wr_hit;
	logic rd_res;
	assign run = mode_r[MODE_RUN_BIT];
	assign cmp_en = mode_r[MODE_CMP_BIT];
	assign fr = mode_r[MODE_FR_LSB+3:MODE_FR_LSB];
	// ****************************************
	// Conversion clock divider
	// ****************************************
	always_comb begin
		if (fr[3]) begin
			div_max = 6'h0F;
		end else begin
			unique case (fr[2:0])
				3'h0: div_max = 6'h0B;
				3'h1: div_max = 6'h07;
				3'h2: div_max = 6'h05;
				3'h3: div_max = 6'h03;
				3'h4: div_max = 6'h02;
				default: div_max = 6'h01;
			endcase
		end
	end
	assign step = (div_r == div_max);
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			div_r <= 6'h00;
		end else if (state_r == ST_IDLE || step) begin
			div_r <= 6'h00;
		end else begin
			div_r <= div_r + 6'h01;
		end
	end
	// ****************************************
	// Register bus
	// ****************************************
	assign wr_hit = BUS_WR && !wait_r;
	assign rd_res = BUS_RD && (BUS_ADDR == ADDR_RES_LO || BUS_ADDR == ADDR_RES_HI
		|| BUS_ADDR == ADDR_RES_BYTE);
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= !wait_r && (rd_res || (BUS_WR && BUS_ADDR == ADDR_MODE));
		end
	end
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			mode_r <= MODE_RESET;
			chan_r <= CHAN_RESET;
			pincfg_r <= PINCFG_RESET;
			pfunc_r <= PFUNC_RESET;
			pdir_r <= PDIR_RESET;
		end else if (wr_hit) begin
			unique case (BUS_ADDR)
				ADDR_MODE: mode_r <= BUS_WDATA;
				ADDR_CHAN: chan_r <= BUS_WDATA[2:0];
				ADDR_PINCFG: pincfg_r <= BUS_WDATA[5:0];
				ADDR_PFUNC: pfunc_r <= BUS_WDATA[5:0];
				ADDR_PDIR: pdir_r <= BUS_WDATA[5:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rdata_r <= 8'h00;
		end else if (BUS_RD) begin
			unique case (BUS_ADDR)
				ADDR_MODE: rdata_r <= mode_r;
				ADDR_RES_HI: rdata_r <= result_r[9:2];
				ADDR_RES_LO: rdata_r <= {result_r[1:0], 6'h00};
				ADDR_RES_BYTE: rdata_r <= res_byte_r;
				ADDR_CHAN: rdata_r <= {5'h00, chan_r};
				ADDR_PINCFG: rdata_r <= {2'h0, pincfg_r};
				ADDR_PFUNC: rdata_r <= {2'h0, pfunc_r};
				ADDR_PDIR: rdata_r <= {2'h0, pdir_r};
				default: rdata_r <= 8'h00;
			endcase
		end
	end
	// ****************************************
	// Comparator settling
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			settle_r <= 8'h00;
		end else if (!(cmp_en || run)) begin
			settle_r <= 8'h00;
		end else if (settle_r != 8'(SETTLE_CYC)) begin
			settle_r <= settle_r + 8'h01;
		end
	end
	// ****************************************
	// Conversion sequencer
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= ST_IDLE;
			sar_r <= 10'h000;
			bit_r <= 4'h0;
			samp_r <= 2'h0;
			first_r <= 1'b1;
			first_bad_r <= 1'b0;
		end else if (!run) begin
			state_r <= ST_IDLE;
			first_r <= 1'b1;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					state_r <= ST_SAMPLE;
					samp_r <= 2'h0;
					first_bad_r <= first_r && (settle_r != 8'(SETTLE_CYC));
				end
				ST_SAMPLE: if (step) begin
					if (samp_r == 2'(SAMPLE_STEPS - 1)) begin
						state_r <= ST_CONV;
						sar_r <= 10'h200;
						bit_r <= 4'd9;
					end else begin
						samp_r <= samp_r + 2'h1;
					end
				end
				ST_CONV: if (step) begin
					sar_r[bit_r] <= CMP_OUT;
					if (bit_r == 4'h0) begin
						state_r <= ST_DONE;
					end else begin
						sar_r[bit_r - 4'h1] <= 1'b1;
						bit_r <= bit_r - 4'h1;
					end
				end
				ST_DONE: begin
					state_r <= ST_SAMPLE;
					samp_r <= 2'h0;
					first_r <= 1'b0;
					first_bad_r <= 1'b0;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
	// ****************************************
	// Results and interrupt
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			result_r <= 10'h000;
			res_byte_r <= 8'h00;
			done_r <= 1'b0;
			inval_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (run && state_r == ST_DONE) begin
				result_r <= sar_r;
				res_byte_r <= sar_r[9:2];
				done_r <= 1'b1;
				inval_r <= first_bad_r;
			end
		end
	end
	// ****************************************
	// Pin and analog outputs
	// ****************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			CMP_POWER <= 1'b0;
			DAC_CODE <= 10'h000;
			SH_TRACK <= 1'b0;
			SH_CHANNEL <= CHAN_RESET;
			PIN_ANALOG <= '0;
			PIN_SEGMENT <= '0;
			PIN_OE <= '0;
		end else begin
			CMP_POWER <= cmp_en || run;
			DAC_CODE <= sar_r;
			SH_TRACK <= run && state_r == ST_SAMPLE;
			SH_CHANNEL <= chan_r;
			for (int i = 0; i < NPINS; i++) begin
				PIN_ANALOG[i] <= !pincfg_r[i] && run && (chan_r == 3'(i));
				PIN_SEGMENT[i] <= pfunc_r[i] && pincfg_r[i];
				PIN_OE[i] <= pincfg_r[i] && !pfunc_r[i] && !pdir_r[i];
			end
		end
	end
	assign BUS_RDATA = rdata_r;
	assign BUS_WAIT = wait_r;
	assign RESULT_INVALID = inval_r;
	assign DONE_IRQ = done_r;
	// ****************************************
	// Assertions
	// ****************************************
	a_done_updates: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		DONE_IRQ |-> result_r == $past(sar_r)) else $error("result not loaded");
	a_byte_matches: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		DONE_IRQ |-> res_byte_r == result_r[9:2]) else $error("byte mismatch");
	a_abort_quiet: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!run |=> !DONE_IRQ) else $error("irq after abort");
	a_wait_read: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		rd_res && !wait_r |=> BUS_WAIT) else $error("no read wait");
	a_wait_write: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		BUS_WR && BUS_ADDR == ADDR_MODE && !wait_r |=> BUS_WAIT ##1 !BUS_WAIT)
		else $error("no write wait");
	a_msb_first: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		state_r == ST_SAMPLE ##1 state_r == ST_CONV |-> bit_r == 4'd9)
		else $error("not msb first");
	a_irq_pulse: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		DONE_IRQ |=> !DONE_IRQ) else $error("irq not pulse");
	a_cmp_off: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		!cmp_en && !run |=> !CMP_POWER) else $error("comparator powered");
	a_low_zero: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		BUS_RD && BUS_ADDR == ADDR_RES_LO |=> BUS_RDATA[5:0] == 6'h00)
		else $error("low bits nonzero");
	a_hold_conv: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		state_r == ST_CONV |=> !SH_TRACK) else $error("tracking during conversion");
	a_high_byte: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		BUS_RD && BUS_ADDR == ADDR_RES_HI |=> BUS_RDATA == $past(result_r[9:2]))
		else $error("high byte wrong");
	a_first_flag: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
		state_r == ST_IDLE && run && settle_r != 8'(SETTLE_CYC) |=> first_bad_r)
		else $error("unsettled start not flagged");
endmodule

// *** include/sac_pkg.sv ***
/*
 Constants for the successive-approximation converter control block.
 Assumes a 100 MHz peripheral clock and an 8-bit internal CPU bus.
*/
package sac_pkg;
	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [15:0] ADDR_MODE = 16'hFF8D;
	localparam logic [15:0] ADDR_RES_LO = 16'hFF06;
	localparam logic [15:0] ADDR_RES_HI = 16'hFF07;
	localparam logic [15:0] ADDR_RES_BYTE = 16'hFF08;
	localparam logic [15:0] ADDR_CHAN = 16'hFF09;
	localparam logic [15:0] ADDR_PINCFG = 16'hFF0A;
	localparam logic [15:0] ADDR_PFUNC = 16'hFF0B;
	localparam logic [15:0] ADDR_PDIR = 16'hFF0C;
	// ****************************************
	// Mode register fields and resets
	// ****************************************
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_CMP_BIT = 0;
	localparam int MODE_FR_LSB = 3;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [5:0] PINCFG_RESET = 6'h00;
	localparam logic [5:0] PFUNC_RESET = 6'h00;
	localparam logic [5:0] PDIR_RESET = 6'h3F;
	localparam logic [2:0] CHAN_RESET = 3'h0;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 100;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int RES_BITS = 10;
	localparam int SAMPLE_STEPS = 2;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_CONV = 4'b0100,
		ST_DONE = 4'b1000
	} sac_state_t;
endpackage

// *** sim/sac_analog_model.sv ***
/*
 Far side of the converter: six analog levels, sample-and-hold, comparator.
 Assumes DAC_CODE and SH_TRACK from the controller, one clock domain.
*/
`timescale 1ns/1ns
module sac_analog_model (
	input wire logic clk, // Peripheral clock
	input wire logic rst_n, // Async reset, low
	input wire logic [59:0] levels, // Ten-bit level per pin
	input wire logic sh_track, // Tracking request
	input wire logic [2:0] sh_channel, // Routed pin
	input wire logic [9:0] dac_code, // Tap code
	input wire logic cmp_power, // Comparator powered
	output logic cmp_out // Decision
);
	logic [9:0] held_r;
	logic [6:0] settle_r;
	logic toggle_r;
	// ****************************************
	// Sample-and-hold
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held_r <= 10'h000;
		end else if (sh_track) begin
			held_r <= levels[int'(sh_channel) * 10 +: 10];
		end
	end
	// ****************************************
	// Comparator, garbage until settled
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_r <= 7'h00;
		end else if (!cmp_power) begin
			settle_r <= 7'h00;
		end else if (settle_r != 7'h64) begin
			settle_r <= settle_r + 7'h01;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle_r <= 1'b0;
		end else begin
			toggle_r <= ~toggle_r;
		end
	end
	assign cmp_out = (settle_r == 7'h64) ? (held_r >= dac_code) : toggle_r;
endmodule

// *** sim/tb_top.sv ***
/*
 Self-checking bench for the converter controller with the analog model.
 Assumes the single-cycle CPU bus with wait output described by the controller.
*/
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("mismatch %s expected %h seen %h", nm, exp, got); \
	end \
end
module tb_top import sac_pkg::*;;
	logic clk_sys = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, cmp_out, cmp_power;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00, bus_rdata;
	logic bus_wait, sh_track, result_invalid, done_irq;
	logic [9:0] dac_code;
	logic [2:0] sh_channel;
	logic [5:0] pin_analog, pin_segment, pin_oe;
	logic [59:0] levels = 60'h0;
	int err_total = 0, tests_run = 0, cyc = 0;
	sac_ctrl sac_ctrl_inst (.CLK_SYS(clk_sys), .RSTN(rstn), .BUS_ADDR(bus_addr),
		.BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
		.BUS_WAIT(bus_wait), .CMP_OUT(cmp_out), .CMP_POWER(cmp_power), .DAC_CODE(dac_code),
		.SH_TRACK(sh_track), .SH_CHANNEL(sh_channel), .PIN_ANALOG(pin_analog),
		.PIN_SEGMENT(pin_segment), .PIN_OE(pin_oe), .RESULT_INVALID(result_invalid),
		.DONE_IRQ(done_irq));
	sac_analog_model sac_analog_model_inst (.clk(clk_sys), .rst_n(rstn), .levels(levels),
		.sh_track(sh_track), .sh_channel(sh_channel), .dac_code(dac_code),
		.cmp_power(cmp_power), .cmp_out(cmp_out));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic finish_test();
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			finish_test();
		end
	end
	// ****************************************
	// Bus and wait helpers
	// ****************************************
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK("write wait", (a == ADDR_MODE), bus_wait)
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk_sys);
		bus_rd <= 1'b0;
		#1;
		`CHK("read data", exp, bus_rdata)
		`CHK("read wait", (a inside {ADDR_RES_LO, ADDR_RES_HI, ADDR_RES_BYTE}), bus_wait)
	endtask
	task automatic wait_done();
		int n;
		for (n = 0; n < 3000 && done_irq !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK("done seen", 1'b1, done_irq)
		@(posedge clk_sys);
		#1;
		`CHK("done pulse", 1'b0, done_irq)
	endtask
	task automatic chk_period(input int div);
		int n;
		wait_done();
		for (n = 1; n < 1000 && done_irq !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK("conv period", (SAMPLE_STEPS + RES_BITS) * div, n)
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd(ADDR_MODE, MODE_RESET);
		rd(ADDR_RES_HI, 8'h00);
		rd(ADDR_RES_BYTE, 8'h00);
		rd(16'hFF30, 8'h00);
		`CHK("oe reset", 6'h00, pin_oe)
		`CHK("power reset", 1'b0, cmp_power)
		$display("test reset done");
	endtask
	task automatic t_power();
		wr(ADDR_MODE, 8'h01);
		`CHK("wait power", 1'b1, cmp_power)
		rd(ADDR_MODE, 8'h01);
		wr(ADDR_MODE, 8'h00);
		`CHK("stopped", 1'b0, cmp_power)
		$display("test power done");
	endtask
	task automatic t_pins();
		wr(ADDR_PINCFG, 8'h38);
		wr(ADDR_PFUNC, 8'h0C);
		wr(ADDR_PDIR, 8'h20);
		wr(ADDR_CHAN, 8'h02);
		@(posedge clk_sys);
		#1;
		`CHK("segment", 6'h08, pin_segment)
		`CHK("port oe", 6'h10, pin_oe)
		`CHK("analog idle", 6'h00, pin_analog)
		$display("test pins done");
	endtask
	task automatic t_conv();
		levels[29:20] = 10'h2B5;
		wr(ADDR_MODE, 8'h01);
		repeat (110) @(posedge clk_sys);
		wr(ADDR_MODE, 8'hA9);
		wait_done();
		`CHK("valid", 1'b0, result_invalid)
		`CHK("analog pin", 6'h04, pin_analog)
		`CHK("seg kept", 6'h08, pin_segment)
		`CHK("channel", 3'h2, sh_channel)
		rd(ADDR_RES_HI, 8'hAD);
		rd(ADDR_RES_LO, 8'h40);
		rd(ADDR_RES_BYTE, 8'hAD);
		chk_period(2);
		wr(ADDR_MODE, 8'h28);
		$display("test conv done");
	endtask
	task automatic t_invalid();
		int n;
		levels[29:20] = 10'h0C3;
		wr(ADDR_MODE, 8'hC0);
		wait_done();
		`CHK("first invalid", 1'b1, result_invalid)
		for (n = 0; n < 10 && result_invalid !== 1'b0; n++) begin
			wait_done();
		end
		`CHK("later valid", 1'b0, result_invalid)
		rd(ADDR_RES_HI, 8'h30);
		rd(ADDR_RES_LO, 8'hC0);
		rd(ADDR_RES_BYTE, 8'h30);
		$display("test invalid done");
	endtask
	task automatic t_abort();
		int n;
		wait_done();
		levels[29:20] = 10'h3FF;
		repeat (6) @(posedge clk_sys);
		wr(ADDR_MODE, 8'h40);
		for (n = 0; n < 300; n++) begin
			@(posedge clk_sys);
			#1;
			if (done_irq !== 1'b0) `CHK("no done", 1'b0, done_irq)
		end
		rd(ADDR_RES_HI, 8'h30);
		$display("test abort done");
	endtask
	task automatic t_rates();
		int div_of[5] = '{12, 8, 6, 4, 3};
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_MODE, {1'b1, 4'(i), 3'b000});
			chk_period(div_of[i]);
			wr(ADDR_MODE, {1'b0, 4'(i), 3'b000});
		end
		$display("test rates done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_power();
		t_pins();
		t_conv();
		t_invalid();
		t_abort();
		t_rates();
		finish_test();
	end
endmodule
